/* verilog/pwm_compare_a_value_pkg.sv */
/*
 * pwm_compare_a_value_pkg: constants, register map, field positions and state types
 * for the time-base status and compare-A block.
 * Assumes one APB slave on a 32-bit bus, byte addresses, and one clock pclk.
 *
// Summary of operation
// [RULE1] counter top 0xFFFF sets flag; write-one clears
// [RULE2] top flag zero unless top reached since clear
// [RULE3] sync input pulse latches flag; write-one clears
// [RULE4] status bit 0 shows up(1) or down(0)
// [RULE5] direction reads one after reset, meaningless frozen
// [RULE6] counter equal compare-A raises match event
// [RULE7] match event forwarded to output action logic
// [RULE8] actions: ignore, low, high, invert per output
// [RULE9] compare-A is shadowed after reset
// [RULE10] shadow select zero: access hits shadow copy
// [RULE11] shadow copied to active on chosen event
// [RULE12] shadow full flag readable before writing
// [RULE13] shadow select one: access hits active copy
// [RULE14] both copies share one address
// [RULE15] mode: up, down, up-down, frozen (reset)
// [RULE16] full set by shadow write, cleared by load
// [RULE17] status reserved bits read zero, ignore writes
 */
`default_nettype none

package pwm_compare_a_value_pkg;

    localparam int APB_ADDR_W = 8;

    localparam logic [7:0] OFF_TB_CONTROL  = 8'h00;
    localparam logic [7:0] OFF_TB_STATUS   = 8'h04;
    localparam logic [7:0] OFF_TB_PERIOD   = 8'h08;
    localparam logic [7:0] OFF_TB_COUNTER  = 8'h0C;
    localparam logic [7:0] OFF_COMPARE_A_VALUE_VALUE  = 8'h10;
    localparam logic [7:0] OFF_CMP_CONTROL = 8'h14;
    localparam logic [7:0] OFF_ACTION_CTRL = 8'h18;
    localparam logic [7:0] OFF_INT_STATUS  = 8'h1C;
    localparam logic [7:0] OFF_INT_MASK    = 8'h20;

    // timebase_status fields
    localparam int ST_DIR_BIT  = 0;
    localparam int ST_SYNC_BIT = 1;
    localparam int ST_TOP_BIT  = 2;
    // compare_control fields
    localparam int CC_LOAD_LSB   = 0;
    localparam int CC_SHADOW_BIT = 4;
    localparam int CC_FULL_BIT   = 8;
    // action control fields: two bits per output
    localparam int AC_ONE_LSB = 0;
    localparam int AC_TWO_LSB = 2;
    // interrupt status / mask fields
    localparam int IRQ_TOP_BIT   = 0;
    localparam int IRQ_SYNC_BIT  = 1;
    localparam int IRQ_MATCH_BIT = 2;

    localparam logic [15:0] COUNTER_TOP    = 16'hFFFF;
    localparam logic [15:0] PERIOD_RESET   = 16'hFFFF;
    localparam logic [15:0] COMPARE_A_VALUE_RESET     = 16'h0000;
    localparam logic        DIR_RESET      = 1'b1;

    typedef enum logic [1:0] {
        MODE_UP, MODE_DOWN, MODE_UPDOWN, MODE_FROZEN
    } counter_mode_type;

    typedef enum logic [1:0] {
        LOAD_AT_ZERO, LOAD_AT_PERIOD, LOAD_AT_ZERO_OR_PERIOD, LOAD_NEVER
    } load_event_type;

    typedef enum logic [1:0] {
        ACT_NONE, ACT_LOW, ACT_HIGH, ACT_TOGGLE
    } action_type;

    typedef struct packed {
        logic                  psel;
        logic                  penable;
        logic                  pwrite;
        logic [APB_ADDR_W-1:0] paddr;
        logic [31:0]           pwdata;
    } apb_req_type;

    typedef struct packed {
        counter_mode_type counter_mode_select;
        logic [15:0]      period;
        logic [15:0]      timebase_counter;
        logic             count_direction_bit;
        logic             counter_top_reached_flag;
        logic             sync_input_seen_flag;
        logic [15:0]      compare_a_value_active;
        logic [15:0]      compare_a_value_shadow;
        logic             compare_a_shadow_select;
        load_event_type   compare_a_load_event_select;
        logic             compare_a_shadow_full_flag;
        action_type       output_one_action_control;
        action_type       output_two_action_control;
        logic             pwm_output_one;
        logic             pwm_output_two;
        logic             compare_a_event;
        logic [2:0]       int_status;
        logic [2:0]       int_mask;
        logic [31:0]      prdata;
        logic             pslverr;
    } state_type;

    localparam state_type STATE_RESET = '{
        counter_mode_select:         MODE_FROZEN,
        period:                      PERIOD_RESET,
        timebase_counter:            16'h0000,
        count_direction_bit:         DIR_RESET,
        counter_top_reached_flag:    1'b0,
        sync_input_seen_flag:        1'b0,
        compare_a_value_active:                 COMPARE_A_VALUE_RESET,
        compare_a_value_shadow:                 COMPARE_A_VALUE_RESET,
        compare_a_shadow_select:     1'b0,
        compare_a_load_event_select: LOAD_AT_ZERO,
        compare_a_shadow_full_flag:  1'b0,
        output_one_action_control:   ACT_NONE,
        output_two_action_control:   ACT_NONE,
        pwm_output_one:              1'b0,
        pwm_output_two:              1'b0,
        compare_a_event:             1'b0,
        int_status:                  3'h0,
        int_mask:                    3'h0,
        prdata:                      32'h00000000,
        pslverr:                     1'b0
    };

endpackage

`default_nettype wire

/* verilog/pwm_compare_a_value.sv */
/*
 * pwm_compare_a_value: time-base counter with status flags, compare-A channel with
 * shadow register, compare-A output actions, APB register slave and one
 * level interrupt.
 * Assumes APB inputs and external_sync_input synchronous to pclk; ce low
 * freezes every flip-flop and stretches APB transfers.
 */
// The address map and register access over APB were decided locally.
`default_nettype none

module pwm_compare_a_value
    import pwm_compare_a_value_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        ce,
    input  wire apb_req_type apb_req,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        external_sync_input,
    output logic             compare_a_event,
    output logic             pwm_output_one,
    output logic             pwm_output_two,
    output logic             irq
);

    state_type state_r;
    state_type state_nxt;

    function automatic logic is_mapped(input logic [APB_ADDR_W-1:0] addr);
        case (addr)
            OFF_TB_CONTROL, OFF_TB_STATUS, OFF_TB_PERIOD, OFF_TB_COUNTER,
            OFF_COMPARE_A_VALUE_VALUE, OFF_CMP_CONTROL, OFF_ACTION_CTRL,
            OFF_INT_STATUS, OFF_INT_MASK: is_mapped = 1'b1;
            default: is_mapped = 1'b0;
        endcase
    endfunction

    function automatic logic apply_action(input logic cur, input action_type act);
        case (act)
            ACT_LOW:    apply_action = 1'b0;
            ACT_HIGH:   apply_action = 1'b1;
            ACT_TOGGLE: apply_action = ~cur;
            default:    apply_action = cur;
        endcase
    endfunction

    logic        setup_phase;
    logic        wr_access;
    logic [31:0] wdata;
    logic        running;
    logic        at_zero;
    logic        at_period;
    logic        match;
    logic        load_strobe;
    logic [15:0] compare_a_value_view;

    assign pready      = ce;
    assign setup_phase = apb_req.psel & ~apb_req.penable;
    assign wr_access   = apb_req.psel & apb_req.penable & apb_req.pwrite
                         & is_mapped(apb_req.paddr);
    assign wdata       = apb_req.pwdata;

    assign running   = state_r.counter_mode_select != MODE_FROZEN;
    assign at_zero   = state_r.timebase_counter == 16'h0000;
    assign at_period = state_r.timebase_counter == state_r.period;
    assign match     = running && (state_r.timebase_counter == state_r.compare_a_value_active); // RULE6

    always_comb begin
        case (state_r.compare_a_load_event_select) // RULE11
            LOAD_AT_ZERO:           load_strobe = running & at_zero;
            LOAD_AT_PERIOD:         load_strobe = running & at_period;
            LOAD_AT_ZERO_OR_PERIOD: load_strobe = running & (at_zero | at_period);
            default:                load_strobe = 1'b0;
        endcase
    end

    // single address, the select bit alone picks the copy
    assign compare_a_value_view = state_r.compare_a_shadow_select ? state_r.compare_a_value_active // RULE13 RULE14
                                                       : state_r.compare_a_value_shadow; // RULE10

    always_comb begin
        state_nxt = state_r;

        // time-base counter; mode change applies from the current count
        case (state_r.counter_mode_select) // RULE15
            MODE_UP: begin
                state_nxt.count_direction_bit = 1'b1; // RULE4
                if (state_r.timebase_counter >= state_r.period) begin
                    state_nxt.timebase_counter = 16'h0000;
                end else begin
                    state_nxt.timebase_counter = state_r.timebase_counter + 16'h0001;
                end
            end
            MODE_DOWN: begin
                state_nxt.count_direction_bit = 1'b0; // RULE4
                if (at_zero) begin
                    state_nxt.timebase_counter = state_r.period;
                end else begin
                    state_nxt.timebase_counter = state_r.timebase_counter - 16'h0001;
                end
            end
            MODE_UPDOWN: begin
                if (state_r.count_direction_bit) begin
                    if (state_r.timebase_counter >= state_r.period) begin
                        state_nxt.count_direction_bit = 1'b0; // RULE4
                        state_nxt.timebase_counter    = state_r.timebase_counter - 16'h0001;
                    end else begin
                        state_nxt.timebase_counter = state_r.timebase_counter + 16'h0001;
                    end
                end else begin
                    if (at_zero) begin
                        state_nxt.count_direction_bit = 1'b1; // RULE4
                        state_nxt.timebase_counter    = state_r.timebase_counter + 16'h0001;
                    end else begin
                        state_nxt.timebase_counter = state_r.timebase_counter - 16'h0001;
                    end
                end
            end
            default: begin
                // frozen: direction keeps its last value and means nothing
                state_nxt.timebase_counter = state_r.timebase_counter; // RULE5
            end
        endcase

        // compare-A event to the action stage, one cycle pulse
        state_nxt.compare_a_event = match; // RULE7
        if (match) begin
            state_nxt.pwm_output_one = apply_action(state_r.pwm_output_one,
                                                    state_r.output_one_action_control); // RULE8
            state_nxt.pwm_output_two = apply_action(state_r.pwm_output_two,
                                                    state_r.output_two_action_control); // RULE8
        end

        // shadow load; a write in the same cycle re-fills the shadow below
        if (!state_r.compare_a_shadow_select && load_strobe) begin
            state_nxt.compare_a_value_active                = state_r.compare_a_value_shadow; // RULE11
            state_nxt.compare_a_shadow_full_flag = 1'b0; // RULE16
        end

        // register writes; W1C clears first so hardware sets win
        state_nxt.pslverr = 1'b0;
        if (wr_access) begin
            case (apb_req.paddr)
                OFF_TB_CONTROL: begin
                    state_nxt.counter_mode_select = counter_mode_type'(wdata[1:0]); // RULE15
                end
                OFF_TB_STATUS: begin
                    // only the two sticky bits react; the rest is read-only
                    if (wdata[ST_TOP_BIT]) begin
                        state_nxt.counter_top_reached_flag = 1'b0; // RULE1
                    end
                    if (wdata[ST_SYNC_BIT]) begin
                        state_nxt.sync_input_seen_flag = 1'b0; // RULE3
                    end
                end
                OFF_TB_PERIOD: begin
                    state_nxt.period = wdata[15:0];
                end
                OFF_COMPARE_A_VALUE_VALUE: begin
                    if (state_r.compare_a_shadow_select) begin
                        state_nxt.compare_a_value_active = wdata[15:0]; // RULE13
                    end else begin
                        state_nxt.compare_a_value_shadow                = wdata[15:0]; // RULE10
                        state_nxt.compare_a_shadow_full_flag = 1'b1; // RULE16
                    end
                end
                OFF_CMP_CONTROL: begin
                    state_nxt.compare_a_shadow_select     = wdata[CC_SHADOW_BIT];
                    state_nxt.compare_a_load_event_select =
                        load_event_type'(wdata[CC_LOAD_LSB +: 2]);
                end
                OFF_ACTION_CTRL: begin
                    state_nxt.output_one_action_control = action_type'(wdata[AC_ONE_LSB +: 2]);
                    state_nxt.output_two_action_control = action_type'(wdata[AC_TWO_LSB +: 2]);
                end
                OFF_INT_STATUS: begin
                    state_nxt.int_status = state_r.int_status & ~wdata[2:0];
                end
                OFF_INT_MASK: begin
                    state_nxt.int_mask = wdata[2:0];
                end
                default: begin
                    state_nxt.pslverr = 1'b0;
                end
            endcase
        end

        // hardware sets, after the clears
        if (state_r.timebase_counter == COUNTER_TOP) begin
            state_nxt.counter_top_reached_flag = 1'b1; // RULE1 RULE2
            state_nxt.int_status[IRQ_TOP_BIT]  = 1'b1;
        end
        if (external_sync_input) begin
            state_nxt.sync_input_seen_flag     = 1'b1; // RULE3
            state_nxt.int_status[IRQ_SYNC_BIT] = 1'b1;
        end
        if (match) begin
            state_nxt.int_status[IRQ_MATCH_BIT] = 1'b1;
        end

        // read data and error captured in the setup cycle, shown in access
        if (setup_phase) begin
            state_nxt.prdata  = 32'h00000000;
            state_nxt.pslverr = ~is_mapped(apb_req.paddr);
            case (apb_req.paddr)
                OFF_TB_CONTROL: begin
                    state_nxt.prdata[1:0] = state_r.counter_mode_select;
                end
                OFF_TB_STATUS: begin
                    // upper bits stay zero
                    state_nxt.prdata[ST_TOP_BIT]  = state_r.counter_top_reached_flag; // RULE17
                    state_nxt.prdata[ST_SYNC_BIT] = state_r.sync_input_seen_flag;
                    state_nxt.prdata[ST_DIR_BIT]  = state_r.count_direction_bit; // RULE4
                end
                OFF_TB_PERIOD: begin
                    state_nxt.prdata[15:0] = state_r.period;
                end
                OFF_TB_COUNTER: begin
                    state_nxt.prdata[15:0] = state_r.timebase_counter;
                end
                OFF_COMPARE_A_VALUE_VALUE: begin
                    state_nxt.prdata[15:0] = compare_a_value_view; // RULE14
                end
                OFF_CMP_CONTROL: begin
                    state_nxt.prdata[CC_LOAD_LSB +: 2] = state_r.compare_a_load_event_select;
                    state_nxt.prdata[CC_SHADOW_BIT]    = state_r.compare_a_shadow_select;
                    state_nxt.prdata[CC_FULL_BIT]      = state_r.compare_a_shadow_full_flag; // RULE12
                end
                OFF_ACTION_CTRL: begin
                    state_nxt.prdata[AC_ONE_LSB +: 2] = state_r.output_one_action_control;
                    state_nxt.prdata[AC_TWO_LSB +: 2] = state_r.output_two_action_control;
                end
                OFF_INT_STATUS: begin
                    state_nxt.prdata[2:0] = state_r.int_status;
                end
                OFF_INT_MASK: begin
                    state_nxt.prdata[2:0] = state_r.int_mask;
                end
                default: begin
                    state_nxt.prdata = 32'h00000000;
                end
            endcase
        end
    end

    // reset state: frozen counter, shadowed compare-A, direction one
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r <= STATE_RESET; // RULE5 RULE9
        end else if (ce) begin
            state_r <= state_nxt;
        end
    end

    assign prdata          = state_r.prdata;
    assign pslverr         = state_r.pslverr & apb_req.psel & apb_req.penable;
    assign compare_a_event = state_r.compare_a_event;
    assign pwm_output_one  = state_r.pwm_output_one;
    assign pwm_output_two  = state_r.pwm_output_two;
    assign irq             = |(state_r.int_status & state_r.int_mask);

endmodule

`default_nettype wire

/* dv/pwm_compare_a_value_sva.sv */
/*
 * pwm_compare_a_value_sva: port-level checks of the compare-A block.
 * Assumes a bind from the bench top; sees only the top module's ports.
 */
`default_nettype none

module pwm_compare_a_value_sva
    import pwm_compare_a_value_pkg::*;
(
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        ce,
    input wire apb_req_type apb_req,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        compare_a_event,
    input wire logic        pwm_output_one,
    input wire logic        pwm_output_two,
    input wire logic        irq
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence acc_s;
        apb_req.psel && apb_req.penable && ce;
    endsequence
    sequence frz_s;
        acc_s ##0 (apb_req.pwrite && apb_req.paddr == OFF_TB_CONTROL
            && apb_req.pwdata[1:0] == 2'h3);
    endsequence
    sequence rd_st_s;
        acc_s ##0 (!apb_req.pwrite && apb_req.paddr == OFF_TB_STATUS);
    endsequence
    sequence unm_s;
        acc_s ##0 (apb_req.paddr > OFF_INT_MASK);
    endsequence

    pready_follow_a: assert property (pready == ce)
        else $error("pready differs from ce");
    unmapped_err_a: assert property (unm_s |-> pslverr)
        else $error("no error on unmapped access");
    unmapped_zero_a: assert property (unm_s ##0 !apb_req.pwrite |-> prdata == 32'h0)
        else $error("unmapped read not zero");
    mapped_ok_a: assert property (acc_s ##0 (apb_req.paddr <= OFF_INT_MASK
        && apb_req.paddr[1:0] == 2'h0) |-> !pslverr)
        else $error("error on mapped access");
    status_rsvd_a: assert property (rd_st_s |-> prdata[31:3] == 29'h0)
        else $error("status reserved bits set");
    event_pulse_a: assert property ($rose(compare_a_event) |=> !compare_a_event)
        else $error("match event longer than one cycle");
    frozen_quiet_a: assert property (frz_s |=> ##1 !compare_a_event [*8])
        else $error("match event while frozen");
    out_one_cause_a: assert property ($changed(pwm_output_one) |-> compare_a_event)
        else $error("output one moved without match");
    out_two_cause_a: assert property ($changed(pwm_output_two) |-> compare_a_event)
        else $error("output two moved without match");
    mask_off_a: assert property (acc_s ##0 (apb_req.pwrite && apb_req.paddr == OFF_INT_MASK
        && apb_req.pwdata[2:0] == 3'h0) |=> !irq)
        else $error("irq high with all masked");
endmodule

`default_nettype wire

/* dv/sync_source.sv */
/*
 * sync_source: far-side source of the external sync pulse.
 * Assumes fire is driven just after pclk rises; pulse is one cycle.
 */
`default_nettype none

module sync_source (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic fire,
    output logic      sync
);
    // registered so the pulse never lands in the edge that requested it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync <= 1'b0;
        end else begin
            sync <= fire;
        end
    end
endmodule

`default_nettype wire

/* dv/test_pwm_timebase_status_compare_a.sv */
/*
 * test_pwm_timebase_status_compare_a: directed bench over APB.
 * Assumes ce held high; period 0x0010 gives 17 counts per up cycle.
 */
`default_nettype none

module test_pwm_timebase_status_compare_a;
    timeunit 1ns;
    timeprecision 100ps;
    import pwm_compare_a_value_pkg::*;

    localparam logic [31:0] ALL = 32'hFFFFFFFF;
    logic        pclk    = 1'b0;
    logic        presetn = 1'b0;
    logic        ce      = 1'b1;
    logic        fire    = 1'b0;
    apb_req_type req     = '0;
    logic [31:0] prdata, q;
    logic        pready, pslverr, sync, cmp_ev, out_one, out_two, irq, err;
    int          n_mismatch = 0;
    int          tests_run  = 0;
    int          cyc        = 0;
    int          ev, t1, t2;

    sync_source i_sync (.pclk(pclk), .presetn(presetn), .fire(fire), .sync(sync));
    pwm_compare_a_value i_dut (.pclk(pclk), .presetn(presetn), .ce(ce), .apb_req(req),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .external_sync_input(sync),
        .compare_a_event(cmp_ev), .pwm_output_one(out_one), .pwm_output_two(out_two),
        .irq(irq));

    always #2.5 pclk = ~pclk;

    task automatic wrap_up();
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_mismatch++;
            wrap_up();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: %s got %h exp %h", $time, m, got, exp);
        end
    endtask

    // request held until pready seen high at a rising edge
    task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
        @(posedge pclk);
        req <= '{1'b1, 1'b0, w, a, d};
        @(posedge pclk);
        req.penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        q = prdata;
        err = pslverr;
        req.psel <= 1'b0;
        req.penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        xfer(a, 1'b1, d);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
        input string s);
        xfer(a, 1'b0, 32'h0);
        chk(q & m, e, s);
    endtask

    // counts match pulses and output moves over n cycles
    task automatic watch(input int n);
        logic l1, l2;
        ev = 0;
        t1 = 0;
        t2 = 0;
        l1 = out_one;
        l2 = out_two;
        repeat (n) begin
            @(posedge pclk);
            if (cmp_ev === 1'b1) ev++;
            if (out_one !== l1) t1++;
            if (out_two !== l2) t2++;
            l1 = out_one;
            l2 = out_two;
        end
    endtask

    task automatic pulse_sync();
        @(posedge pclk);
        fire <= 1'b1;
        @(posedge pclk);
        fire <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic t_reset();
        rd(OFF_TB_STATUS, ALL, 32'h1, "status reset");
        rd(OFF_TB_CONTROL, ALL, 32'h3, "mode reset");
        rd(OFF_CMP_CONTROL, ALL, 32'h0, "cmp ctrl reset");
        rd(OFF_COMPARE_A_VALUE_VALUE, ALL, 32'h0, "compare_a_value reset");
    endtask

    task automatic t_sync();
        pulse_sync();
        rd(OFF_TB_STATUS, ALL, 32'h3, "sync latched");
        wr(OFF_TB_STATUS, 32'hFFFFFFF8);
        rd(OFF_TB_STATUS, ALL, 32'h3, "zero and reserved write");
        wr(OFF_TB_STATUS, 32'h2);
        rd(OFF_TB_STATUS, ALL, 32'h1, "sync cleared");
    endtask

    task automatic t_top();
        wr(OFF_TB_CONTROL, 32'h1);
        repeat (4) @(posedge pclk);
        rd(OFF_TB_STATUS, 32'h5, 32'h4, "top set, down");
        wr(OFF_TB_CONTROL, 32'h3);
        wr(OFF_TB_STATUS, 32'h4);
        rd(OFF_TB_STATUS, 32'h4, 32'h0, "top cleared");
    endtask

    task automatic t_shadow();
        wr(OFF_TB_PERIOD, 32'h10);
        wr(OFF_COMPARE_A_VALUE_VALUE, 32'h5);
        rd(OFF_CMP_CONTROL, ALL, 32'h100, "full set");
        rd(OFF_COMPARE_A_VALUE_VALUE, ALL, 32'h5, "shadow read");
        watch(20);
        chk(ev, 32'h0, "frozen events");
        wr(OFF_TB_CONTROL, 32'h0);
        repeat (60) @(posedge pclk);
        rd(OFF_CMP_CONTROL, ALL, 32'h0, "full cleared");
        rd(OFF_TB_STATUS, 32'h1, 32'h1, "dir up");
        watch(68);
        chk(ev, 32'h4, "match count");
        wr(OFF_CMP_CONTROL, 32'h3);
        wr(OFF_COMPARE_A_VALUE_VALUE, 32'h100);
        watch(68);
        chk(ev, 32'h4, "load never holds active");
        wr(OFF_CMP_CONTROL, 32'h13);
        wr(OFF_COMPARE_A_VALUE_VALUE, 32'h100);
        watch(68);
        chk(ev, 32'h0, "direct write");
        wr(OFF_COMPARE_A_VALUE_VALUE, 32'h7);
        rd(OFF_COMPARE_A_VALUE_VALUE, ALL, 32'h7, "direct read");
        watch(68);
        chk(ev, 32'h4, "direct match");
    endtask

    task automatic t_action();
        wr(OFF_ACTION_CTRL, 32'hE);
        watch(68);
        chk({31'h0, out_one}, 32'h1, "set high");
        chk(t2, 32'h4, "toggle two");
        wr(OFF_ACTION_CTRL, 32'h1);
        watch(68);
        chk({31'h0, out_one}, 32'h0, "set low");
        chk(t2, 32'h0, "ignore two");
        wr(OFF_ACTION_CTRL, 32'h3);
        watch(68);
        chk(t1, 32'h4, "toggle one");
    endtask

    task automatic t_irq();
        wr(OFF_INT_MASK, 32'h4);
        watch(20);
        chk({31'h0, irq}, 32'h1, "irq on match");
        wr(OFF_INT_MASK, 32'h0);
        wr(OFF_TB_CONTROL, 32'h3);
        wr(OFF_INT_STATUS, 32'h7);
        wr(OFF_INT_MASK, 32'h7);
        @(posedge pclk);
        chk({31'h0, irq}, 32'h0, "irq cleared");
        pulse_sync();
        // flag lands at the edge pulse_sync returns on; look one edge later
        @(posedge pclk);
        chk({31'h0, irq}, 32'h1, "irq on sync");
        wr(OFF_INT_STATUS, 32'h2);
        @(posedge pclk);
        chk({31'h0, irq}, 32'h0, "sync irq cleared");
    endtask

    task automatic t_unmapped();
        rd(8'h40, ALL, 32'h0, "unmapped read");
        chk({31'h0, err}, 32'h1, "unmapped read err");
        wr(8'h40, ALL);
        chk({31'h0, err}, 32'h1, "unmapped write err");
        rd(OFF_TB_PERIOD, ALL, 32'h10, "period intact");
        chk({31'h0, err}, 32'h0, "mapped no err");
    endtask

    initial begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_sync();
        t_top();
        t_shadow();
        t_action();
        t_irq();
        t_unmapped();
        wrap_up();
    end
endmodule

bind pwm_compare_a_value pwm_compare_a_value_sva i_sva (.pclk, .presetn, .ce, .apb_req, .prdata, .pready,
    .pslverr, .compare_a_event, .pwm_output_one, .pwm_output_two, .irq);

`default_nettype wire
